// ---- hdl/pcrb_pkg.sv ----
package pcrb_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_IDENT      = 8'h00;
  localparam logic [7:0] ADDR_MEMVER     = 8'h01;
  localparam logic [7:0] ADDR_BUCK_CTRL  = 8'h02;
  localparam logic [7:0] ADDR_BUCK_LIM   = 8'h03;
  localparam logic [7:0] ADDR_PG_CFG_A   = 8'h15;
  localparam logic [7:0] ADDR_PG_CFG_B   = 8'h16;
  localparam logic [7:0] ADDR_PG_FAULTS  = 8'h17;
  localparam logic [7:0] ADDR_SW_RESET   = 8'h18;
  localparam logic [7:0] ADDR_EVT_TOP_A  = 8'h19;
  localparam logic [7:0] ADDR_EVT_TOP_B  = 8'h1a;
  localparam logic [7:0] ADDR_EVT_CONV   = 8'h1b;
  localparam logic [7:0] ADDR_EVT_LIN    = 8'h1c;
  localparam logic [7:0] ADDR_ST_TOP     = 8'h1d;
  localparam logic [7:0] ADDR_ST_CONV    = 8'h1e;
  localparam logic [7:0] ADDR_ST_LIN     = 8'h1f;
  localparam logic [7:0] ADDR_MSK_TOP_A  = 8'h20;
  localparam logic [7:0] ADDR_MSK_TOP_B  = 8'h21;
  localparam logic [7:0] ADDR_MSK_CONV   = 8'h22;
  localparam logic [7:0] ADDR_MSK_LIN    = 8'h23;
  localparam logic [7:0] ADDR_LOAD_SEL   = 8'h24;
  localparam logic [7:0] ADDR_LOAD_HIGH  = 8'h25;
  localparam logic [7:0] ADDR_LOAD_LOW   = 8'h26;

  // ==========================================================
  // field positions and reset values
  localparam int         BIT_FORCED      = 3;
  localparam int         BIT_DISCHARGE   = 2;
  localparam int         BIT_PIN_GATING  = 1;
  localparam int         BIT_ON          = 0;
  localparam logic [7:0] BUCK_CTRL_WMASK = 8'h0f;
  localparam logic [7:0] BUCK_CTRL_RST   = 8'h07;
  localparam logic [7:0] BUCK_LIM_RST    = 8'h2a;
  localparam logic [5:0] IDENT_LOW_RST   = 6'h02;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam logic [7:0] ALL_ONES        = 8'hff;

  // device address on the serial port
  localparam logic [6:0] DEV_ADDR        = 7'h60;

  // ==========================================================
  // serial engine states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ACK  = 6'b000100,
    ST_RX   = 6'b001000,
    ST_TX   = 6'b010000,
    ST_MACK = 6'b100000
  } pcrb_state_type;

  // status inputs from the analog side
  typedef struct packed {
    logic [7:0] pg_faults;
    logic [7:0] st_top;
    logic [7:0] st_conv;
    logic [7:0] st_lin;
    logic [8:0] load_current;
  } pcrb_status_type;

  // first converter controls
  typedef struct packed {
    logic forced_switching;
    logic discharge_on;
    logic pin_gating;
    logic on;
    logic run;
  } pcrb_conv_type;

  // whole module state
  typedef struct packed {
    logic [1:0]     scl_s;
    logic [1:0]     sda_s;
    logic           scl_prev;
    logic           sda_prev;
    pcrb_state_type st;
    logic [3:0]     bitcnt;
    logic [7:0]     shift;
    logic           is_read;
    logic           have_reg;
    logic [7:0]     index;
    logic           sda_oe;
    logic [7:0]     buck_ctrl;
    logic [7:0]     buck_lim;
    logic [7:0]     pg_cfg_a;
    logic [7:0]     pg_cfg_b;
    logic [7:0]     sw_reset;
    logic [7:0]     evt_top_a;
    logic [7:0]     evt_top_b;
    logic [7:0]     evt_conv;
    logic [7:0]     evt_lin;
    logic [7:0]     msk_top_a;
    logic [7:0]     msk_top_b;
    logic [7:0]     msk_conv;
    logic [7:0]     msk_lin;
    logic [7:0]     load_sel;
    logic [1:0]     en_pin_s;
  } pcrb_regs_type;

endpackage

// ---- hdl/pcrb_bank.sv ----
// Summary of operation
// (R1) bit3 selects automatic or forced switching
// (R2) bit2 enables discharge while converter off
// (R3) bit1 adds enable pin gating
// (R4) bit0 turns converter on; high bits reserved
// (R5) address zero returns part code field
// (R6) address one returns memory version code
// (R7) read-only registers ignore writes
// (R8) access via device address, index, data
// (R9) index increments after written bytes only
`timescale 1ns/100ps
module pcrb_bank #(
  parameter logic [1:0] PART_CODE    = 2'h1,  // arbitrary value
  parameter logic [7:0] MEM_VER_CODE = 8'h11  // arbitrary value
) (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     en_pin,
  input  wire pcrb_pkg::pcrb_status_type status,
  input  wire logic [7:0]               evt_set_top_a,
  input  wire logic [7:0]               evt_set_top_b,
  input  wire logic [7:0]               evt_set_conv,
  input  wire logic [7:0]               evt_set_lin,
  output pcrb_pkg::pcrb_conv_type       conv,
  output logic [7:0]                    buck_limits,
  output logic [7:0]                    pg_config_a,
  output logic [7:0]                    pg_config_b,
  output logic                          soft_reset,
  output logic [7:0]                    mask_top_a,
  output logic [7:0]                    mask_top_b,
  output logic [7:0]                    mask_conv,
  output logic [7:0]                    mask_lin,
  output logic                          load_select
);
  import pcrb_pkg::*;

  pcrb_regs_type q, d;
  logic          scl, sda, scl_rise, scl_fall, start_c, stop_c;
  logic [7:0]    rd_data;

  // ==========================================================
  // synchronised line levels and conditions
  assign scl      = q.scl_s[1];
  assign sda      = q.sda_s[1];
  assign scl_rise = scl & ~q.scl_prev;
  assign scl_fall = ~scl & q.scl_prev;
  assign start_c  = scl & q.scl_prev & q.sda_prev & ~sda;
  assign stop_c   = scl & q.scl_prev & ~q.sda_prev & sda;

  // ==========================================================
  // read multiplexer
  always_comb begin
    case (q.index)
      ADDR_IDENT:     rd_data = {PART_CODE, IDENT_LOW_RST};  // [R5]
      ADDR_MEMVER:    rd_data = MEM_VER_CODE;                // [R6]
      ADDR_BUCK_CTRL: rd_data = q.buck_ctrl;
      ADDR_BUCK_LIM:  rd_data = q.buck_lim;
      ADDR_PG_CFG_A:  rd_data = q.pg_cfg_a;
      ADDR_PG_CFG_B:  rd_data = q.pg_cfg_b;
      ADDR_PG_FAULTS: rd_data = status.pg_faults;
      ADDR_SW_RESET:  rd_data = q.sw_reset;
      ADDR_EVT_TOP_A: rd_data = q.evt_top_a;
      ADDR_EVT_TOP_B: rd_data = q.evt_top_b;
      ADDR_EVT_CONV:  rd_data = q.evt_conv;
      ADDR_EVT_LIN:   rd_data = q.evt_lin;
      ADDR_ST_TOP:    rd_data = status.st_top;
      ADDR_ST_CONV:   rd_data = status.st_conv;
      ADDR_ST_LIN:    rd_data = status.st_lin;
      ADDR_MSK_TOP_A: rd_data = q.msk_top_a;
      ADDR_MSK_TOP_B: rd_data = q.msk_top_b;
      ADDR_MSK_CONV:  rd_data = q.msk_conv;
      ADDR_MSK_LIN:   rd_data = q.msk_lin;
      ADDR_LOAD_SEL:  rd_data = q.load_sel;
      ADDR_LOAD_HIGH: rd_data = {7'h00, status.load_current[8]};
      ADDR_LOAD_LOW:  rd_data = status.load_current[7:0];
      default:        rd_data = ZERO_BYTE;
    endcase
  end

  // ==========================================================
  // next state: serial engine and register writes
  always_comb begin
    d = q;
    d.scl_s    = {q.scl_s[0], scl_in};
    d.sda_s    = {q.sda_s[0], sda_in};
    d.en_pin_s = {q.en_pin_s[0], en_pin};
    d.scl_prev = scl;
    d.sda_prev = sda;
    // event flags: hardware set wins over host clear
    d.evt_top_a = q.evt_top_a | evt_set_top_a;
    d.evt_top_b = q.evt_top_b | evt_set_top_b;
    d.evt_conv  = q.evt_conv | evt_set_conv;
    d.evt_lin   = q.evt_lin | evt_set_lin;
    d.sw_reset  = ZERO_BYTE;  // self-clearing
    if (stop_c) begin
      d.st     = ST_IDLE;
      d.sda_oe = 1'b0;
    end else if (start_c) begin
      d.st       = ST_ADDR;  // [R8]
      d.bitcnt   = 4'h0;
      d.have_reg = 1'b0;
      d.sda_oe   = 1'b0;
    end else begin
      case (q.st)
        ST_IDLE: d.sda_oe = 1'b0;
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            d.shift  = {q.shift[6:0], sda};
            d.bitcnt = q.bitcnt + 4'h1;
          end
          if (scl_fall && q.bitcnt == 4'h8) begin
            d.bitcnt = 4'h0;
            if (q.st == ST_ADDR) begin
              if (q.shift[7:1] == DEV_ADDR) begin  // [R8]
                d.is_read = q.shift[0];
                d.sda_oe  = 1'b1;
                d.st      = ST_ACK;
              end else begin
                d.st = ST_IDLE;
              end
            end else begin
              d.sda_oe = 1'b1;
              d.st     = ST_ACK;
              if (!q.have_reg) begin
                d.index    = q.shift;  // [R8]
                d.have_reg = 1'b1;
              end else begin
                case (q.index)  // read-only offsets fall to default [R7]
                  ADDR_BUCK_CTRL: d.buck_ctrl = q.shift & BUCK_CTRL_WMASK;  // [R1] [R2] [R3] [R4]
                  ADDR_BUCK_LIM:  d.buck_lim  = q.shift;
                  ADDR_PG_CFG_A:  d.pg_cfg_a  = q.shift;
                  ADDR_PG_CFG_B:  d.pg_cfg_b  = q.shift;
                  ADDR_SW_RESET:  d.sw_reset  = q.shift;
                  ADDR_EVT_TOP_A: d.evt_top_a = (q.evt_top_a & ~q.shift) | evt_set_top_a;
                  ADDR_EVT_TOP_B: d.evt_top_b = (q.evt_top_b & ~q.shift) | evt_set_top_b;
                  ADDR_EVT_CONV:  d.evt_conv  = (q.evt_conv & ~q.shift) | evt_set_conv;
                  ADDR_EVT_LIN:   d.evt_lin   = (q.evt_lin & ~q.shift) | evt_set_lin;
                  ADDR_MSK_TOP_A: d.msk_top_a = q.shift;
                  ADDR_MSK_TOP_B: d.msk_top_b = q.shift;
                  ADDR_MSK_CONV:  d.msk_conv  = q.shift;
                  ADDR_MSK_LIN:   d.msk_lin   = q.shift;
                  ADDR_LOAD_SEL:  d.load_sel  = q.shift;
                  default:        d.index     = q.index;
                endcase
                d.index = q.index + 8'h01;  // [R9]
              end
            end
          end
        end
        ST_ACK: begin
          // release ack after ninth clock
          if (scl_fall) begin
            if (q.is_read) begin
              d.st     = ST_TX;
              d.shift  = rd_data;  // no increment on read [R9]
              d.sda_oe = ~rd_data[7];
              d.bitcnt = 4'h1;
            end else begin
              d.st     = ST_RX;
              d.sda_oe = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (q.bitcnt == 4'h8) begin
              d.sda_oe = 1'b0;
              d.st     = ST_MACK;
            end else begin
              d.shift  = {q.shift[6:0], 1'b0};
              d.sda_oe = ~q.shift[6];
              d.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end
        ST_MACK: begin
          // master ack repeats same register, nack ends
          if (scl_rise) begin
            d.st = sda ? ST_IDLE : ST_ACK;
            d.is_read = 1'b1;
          end
        end
        default: d.st = ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q           <= '0;
      q.scl_s     <= 2'b11;
      q.sda_s     <= 2'b11;
      q.scl_prev  <= 1'b1;
      q.sda_prev  <= 1'b1;
      q.st        <= ST_IDLE;
      q.buck_ctrl <= BUCK_CTRL_RST;  // [R2] [R3] [R4]
      q.buck_lim  <= BUCK_LIM_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign sda_out               = 1'b0;  // open drain, low only
  assign sda_oe                = q.sda_oe;
  assign conv.forced_switching = q.buck_ctrl[BIT_FORCED];      // [R1]
  assign conv.discharge_on     = q.buck_ctrl[BIT_DISCHARGE] & ~conv.run;  // [R2]
  assign conv.pin_gating       = q.buck_ctrl[BIT_PIN_GATING];
  assign conv.on               = q.buck_ctrl[BIT_ON];
  assign conv.run              = q.buck_ctrl[BIT_ON]
                                 & (~q.buck_ctrl[BIT_PIN_GATING] | q.en_pin_s[1]);  // [R3] [R4]
  assign buck_limits           = q.buck_lim;
  assign pg_config_a           = q.pg_cfg_a;
  assign pg_config_b           = q.pg_cfg_b;
  assign soft_reset            = q.sw_reset[0];
  assign mask_top_a            = q.msk_top_a;
  assign mask_top_b            = q.msk_top_b;
  assign mask_conv             = q.msk_conv;
  assign mask_lin              = q.msk_lin;
  assign load_select           = q.load_sel[0];

endmodule

// ---- dv/pcrb_bank_sva.sv ----
`timescale 1ns/100ps
// ==========================================================
// port checks of the register bank
module pcrb_bank_sva (
  input wire logic                    clock,
  input wire logic                    arst_n,
  input wire logic                    scl_in,
  input wire logic                    en_pin,
  input wire logic                    sda_out,
  input wire logic                    sda_oe,
  input wire logic                    soft_reset,
  input wire pcrb_pkg::pcrb_conv_type conv
);
  import pcrb_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // converter enable logic
  property p_run_needs_on; conv.run |-> conv.on; endproperty
  a_run_needs_on: assert property (p_run_needs_on) else $error("run without on");
  property p_gate_free; (conv.on && !conv.pin_gating) [*2] |-> conv.run; endproperty
  a_gate_free: assert property (p_gate_free) else $error("ungated run low");
  property p_gate_pin; (conv.pin_gating && !en_pin) [*5] |-> !conv.run; endproperty
  a_gate_pin: assert property (p_gate_pin) else $error("run despite pin low");
  property p_discharge; conv.run |-> !conv.discharge_on; endproperty
  a_discharge: assert property (p_discharge) else $error("discharge while on");
  property p_mode_at_low; !$stable(conv.forced_switching) |-> !scl_in; endproperty
  a_mode_at_low: assert property (p_mode_at_low) else $error("mode moved, scl high");
  // serial pin behaviour
  property p_open_drain; sda_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_oe_at_low; !$stable(sda_oe) |-> !scl_in; endproperty
  a_oe_at_low: assert property (p_oe_at_low) else $error("data moved, scl high");
  property p_soft_pulse; soft_reset |=> !soft_reset; endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset too long");
  c_run: cover property ($rose(conv.run));
  c_ack: cover property ($rose(sda_oe));
  c_soft: cover property (soft_reset);
endmodule

// ---- dv/pcrb_host.sv ----
`timescale 1ns/100ps
// ==========================================================
// serial host model, open drain pull only
module pcrb_host (
  input wire logic clock,
  input wire logic sda,
  output logic     scl,
  output logic     sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // quarter bit, moves on falling clock
  task q;
    repeat (4) @(negedge clock);
  endtask
  // data set while scl low, sampled while high
  task bit_io(input logic b, output logic r);
    q;
    sda_low = !b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
  endtask
  // start or repeated start
  task start;
    q;
    sda_low = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b1;
    q;
    scl = 1'b0;
  endtask
  task stop;
    q;
    sda_low = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b0;
    q;
  endtask
  // byte msb first, then the ack bit
  task xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(last, ak);
  endtask
endmodule

// ---- dv/pcrb_bank_test.sv ----
`timescale 1ns/100ps
// ==========================================================
// bench top
module pcrb_bank_test;
  import pcrb_pkg::*;
  localparam logic [7:0] WA = {DEV_ADDR, 1'b0};
  localparam logic [1:0] PART = 2'h3;   // arbitrary value
  localparam logic [7:0] MEMV = 8'h5c;  // arbitrary value
  logic            clock, arst_n, en_pin, scl, sda_low, sda_oe, a;
  pcrb_status_type status;
  pcrb_conv_type   conv;
  logic [7:0]      r0, r1, d0, d1;
  logic [7:0]      lim_o, pga_o, pgb_o, mta_o, mtb_o, mcv_o, mln_o, ev, ix;
  logic            sr_o, ls_o;
  int              miscompares, comparisons, seed, pulses;
  wire             sda = !(sda_low || sda_oe);  // pull-up
  pcrb_host host (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
  pcrb_bank #(.PART_CODE(PART), .MEM_VER_CODE(MEMV)) DUT (.clock(clock), .arst_n(arst_n),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .en_pin(en_pin), .status(status),
    .evt_set_top_a(ev), .evt_set_top_b(ev), .evt_set_conv(ev), .evt_set_lin(ev), .conv(conv),
    .buck_limits(lim_o), .pg_config_a(pga_o), .pg_config_b(pgb_o), .soft_reset(sr_o),
    .mask_top_a(mta_o), .mask_top_b(mtb_o), .mask_conv(mcv_o), .mask_lin(mln_o),
    .load_select(ls_o));
  // soft reset pulses, looked at between edges
  always @(negedge clock) begin
    if (sr_o === 1'b1) pulses++;
  end
  function logic [7:0] exp_ctrl(input logic [7:0] d);
    return {4'h0, d[3:0]};
  endfunction
  function logic exp_run(input logic [7:0] c, input logic p);
    return c[0] & (!c[1] | p);
  endfunction
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] dv, input logic [7:0] ix, input logic [7:0] x,
          input logic [7:0] y, input int n, output logic nak);
    logic [7:0] t;
    logic       b;
    host.start;
    host.xfer(dv, 1'b1, t, nak);
    host.xfer(ix, 1'b1, t, b);
    host.xfer(x, 1'b1, t, b);
    if (n > 1) host.xfer(y, 1'b1, t, b);
    host.stop;
  endtask
  // two bytes read from one index, both must match
  task rdchk(input string n, input logic [7:0] ix, input logic [7:0] e);
    logic [7:0] t;
    logic       b;
    host.start;
    host.xfer(WA, 1'b1, t, b);
    host.xfer(ix, 1'b1, t, b);
    host.start;
    host.xfer({DEV_ADDR, 1'b1}, 1'b1, t, b);
    host.xfer(8'hff, 1'b0, r0, b);
    host.xfer(8'hff, 1'b1, r1, b);
    host.stop;
    chk(n, r0, e);
    chk(n, r1, e);
  endtask
  task complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (80000) @(posedge clock);
    miscompares++;
    complete_run;
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h09ea;
    arst_n = 1'b0;
    en_pin = 1'b0;
    ev = 8'h00;
    status = '0;
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
    rdchk("ident", ADDR_IDENT, {PART, IDENT_LOW_RST});
    rdchk("memver", ADDR_MEMVER, MEMV);
    rdchk("ctrl_rst", ADDR_BUCK_CTRL, 8'h07);
    chk("disch_rst", {7'h0, conv.discharge_on}, 8'h01);
    // corner values first, then random, two bytes per frame
    for (int i = 0; i < 8; i++) begin
      d0 = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      d1 = 8'($random(seed));
      en_pin = d1[7];
      wr(WA, ADDR_BUCK_CTRL, d0, d1, 2, a);
      chk("ack", {7'h0, a}, 8'h00);
      rdchk("ctrl", ADDR_BUCK_CTRL, exp_ctrl(d0));
      rdchk("limits", ADDR_BUCK_LIM, d1);
      chk("lim_out", lim_o, d1);
      chk("run", {7'h0, conv.run}, {7'h0, exp_run(d0, en_pin)});
      chk("forced", {7'h0, conv.forced_switching}, {7'h0, d0[3]});
      chk("disch", {7'h0, conv.discharge_on}, {7'h0, d0[2] & !exp_run(d0, en_pin)});
    end
    // read-only places ignore writes
    status = 41'({$random(seed), $random(seed)});
    wr(WA, ADDR_IDENT, 8'h3c, 8'hc3, 2, a);
    wr(WA, ADDR_PG_FAULTS, ~status.pg_faults, 8'h00, 1, a);
    wr(WA, ADDR_LOAD_HIGH, 8'hff, 8'h5a, 2, a);
    rdchk("ident_ro", ADDR_IDENT, {PART, IDENT_LOW_RST});
    rdchk("memver_ro", ADDR_MEMVER, MEMV);
    rdchk("faults", ADDR_PG_FAULTS, status.pg_faults);
    rdchk("load_hi", ADDR_LOAD_HIGH, {7'h0, status.load_current[8]});
    rdchk("load_lo", ADDR_LOAD_LOW, status.load_current[7:0]);
    // foreign device address is refused
    wr({DEV_ADDR ^ 7'h01, 1'b0}, ADDR_BUCK_CTRL, 8'h00, 8'h00, 1, a);
    chk("nack", {7'h0, a}, 8'h01);
    rdchk("ctrl_kept", ADDR_BUCK_CTRL, exp_ctrl(d0));
    // soft reset request clears itself, one pulse per request
    wr(WA, ADDR_SW_RESET, 8'h00, 8'h00, 1, a);
    chk("sr_idle", 8'(pulses), 8'h00);
    wr(WA, ADDR_SW_RESET, 8'h01, 8'h00, 1, a);
    rdchk("sw_reset", ADDR_SW_RESET, 8'h00);
    chk("sr_pulse", 8'(pulses), 8'h01);
    // remaining control registers, two per frame except load select, seen at the outputs
    for (int k = 0; k < 3; k++) begin
      ix = (k == 0) ? ADDR_PG_CFG_A : (k == 1) ? ADDR_MSK_TOP_A : ADDR_MSK_CONV;
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      wr(WA, ix, d0, d1, 2, a);
      rdchk("ctl_a", ix, d0);
      rdchk("ctl_b", ix + 8'h01, d1);
      chk("out_a", (k == 0) ? pga_o : (k == 1) ? mta_o : mcv_o, d0);
      chk("out_b", (k == 0) ? pgb_o : (k == 1) ? mtb_o : mln_o, d1);
    end
    wr(WA, ADDR_LOAD_SEL, 8'h01, 8'h00, 1, a);
    rdchk("load_sel", ADDR_LOAD_SEL, 8'h01);
    chk("load_out", {7'h0, ls_o}, 8'h01);
    // state registers ignore writes, unmapped reads zero
    wr(WA, ADDR_ST_TOP, ~status.st_top, ~status.st_conv, 2, a);
    rdchk("st_top", ADDR_ST_TOP, status.st_top);
    rdchk("st_conv", ADDR_ST_CONV, status.st_conv);
    rdchk("st_lin", ADDR_ST_LIN, status.st_lin);
    rdchk("unmapped", 8'h04, 8'h00);
    // event flags: one-cycle set, clear by ones, set wins
    d0 = 8'($random(seed)) | 8'h01;
    d1 = 8'($random(seed));
    ev = d0;
    @(negedge clock);
    ev = 8'h00;
    for (int k = 0; k < 4; k++) rdchk("evt_set", ADDR_EVT_TOP_A + 8'(k), d0);
    wr(WA, ADDR_EVT_TOP_A, d1, d1, 2, a);
    rdchk("evt_clr", ADDR_EVT_TOP_A, d0 & ~d1);
    rdchk("evt_clr", ADDR_EVT_TOP_B, d0 & ~d1);
    ev = d0;
    wr(WA, ADDR_EVT_CONV, 8'hff, 8'hff, 2, a);
    ev = 8'h00;
    rdchk("evt_win", ADDR_EVT_CONV, d0);
    rdchk("evt_win", ADDR_EVT_LIN, d0);
    wr(WA, ADDR_EVT_CONV, 8'hff, 8'hff, 2, a);
    rdchk("evt_gone", ADDR_EVT_CONV, 8'h00);
    // mid-run reset restores defaults
    arst_n = 1'b0;
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
    rdchk("ctrl_rst2", ADDR_BUCK_CTRL, 8'h07);
    rdchk("lim_rst", ADDR_BUCK_LIM, 8'h2a);
    rdchk("evt_rst", ADDR_EVT_LIN, 8'h00);
    complete_run;
  end
endmodule
bind pcrb_bank pcrb_bank_sva u_sva (.clock(clock), .arst_n(arst_n), .scl_in(scl_in),
  .en_pin(en_pin), .sda_out(sda_out), .sda_oe(sda_oe), .soft_reset(soft_reset),
  .conv(conv));
